//--- rtl/tx_dma_pkg.sv
// Shared constants and types for the transmit descriptor DMA.
package tx_dma_pkg;

  // Command word (offset 0) field positions.
  localparam int OWN_BIT        = 31;
  localparam int RING_END_BIT   = 30;
  localparam int FIRST_SEG_BIT  = 29;
  localparam int LAST_SEG_BIT   = 28;
  localparam int LARGE_SEND_BIT = 27;
  localparam int IP_SUM_BIT     = 18;
  localparam int UDP_SUM_BIT    = 17;
  localparam int TCP_SUM_BIT    = 16;
  localparam int LEN_MSB        = 15;

  // Tag word (offset 4) field positions.
  localparam int TAG_INSERT_BIT = 17;
  localparam int TAG_INFO_MSB   = 15;

  // Descriptor layout: four words, sixteen bytes.
  localparam logic [1:0] WORD_CMD     = 2'h0;
  localparam logic [1:0] WORD_TAG     = 2'h1;
  localparam logic [1:0] WORD_ADDR_LO = 2'h2;
  localparam logic [1:0] WORD_ADDR_HI = 2'h3;
  localparam int         DESC_SHIFT   = 4;

  // Frame editing constants.
  localparam logic [15:0] TAG_PROTO_ID   = 16'h8100;
  localparam logic [3:0]  HDR_ADDR_BYTES = 4'hC;
  localparam logic [3:0]  HDR_TAGGED     = 4'hD;
  localparam logic [1:0]  TAG_LAST_POS   = 2'h3;

  // Reset values.
  localparam logic [31:0] WORD_RESET  = 32'h0;
  localparam logic [63:0] ADDR_RESET  = 64'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0;

  // Stream word: {sum[2:0], sop, eop, data[7:0]}.
  localparam int STREAM_W = 13;

  typedef enum logic [2:0] {
    S_IDLE, S_FETCH, S_PAUSE, S_READ, S_EMIT, S_WB
  } dma_state_t;

  typedef enum logic {I_PASS, I_INSERT} ins_state_t;

endpackage : tx_dma_pkg

//--- rtl/tx_byte_fifo.sv
// Parameterised FIFO between the frame editor and the transmit MAC.
`timescale 1ns/1ps
module tx_byte_fifo
  import tx_dma_pkg::*;
#(
  parameter int WIDTH = STREAM_W,
  parameter int DEPTH = 8
) (
  input  logic             clk,
  input  logic             rst_b,
  input  logic             ce,
  input  logic             wr_valid,
  output logic             wr_ready,
  input  logic [WIDTH-1:0] wr_data,
  output logic             rd_valid,
  input  logic             rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  logic [AW-1:0]    next_wp;
  logic [AW-1:0]    next_rp;
  logic [AW:0]      next_cnt;
  logic             push;
  logic             pop;

  assign wr_ready = (cnt != AW'(0) + (AW+1)'(DEPTH));
  assign rd_valid = (cnt != '0);
  assign rd_data  = mem[rp];

  always_comb begin
    push     = wr_valid && wr_ready;
    pop      = rd_valid && rd_ready;
    next_wp  = push ? wp + 1'b1 : wp;
    next_rp  = pop ? rp + 1'b1 : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else if (ce) begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
  end

  // The storage has no reset; only the pointers and count say what is valid.
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wp] <= wr_data;
    end
  end

endmodule : tx_byte_fifo

//--- rtl/tx_tag_inserter.sv
// Inserts the four tag bytes after the address fields of a frame.
`timescale 1ns/1ps
module tx_tag_inserter
  import tx_dma_pkg::*;
(
  input  logic        clk,
  input  logic        rst_b,
  input  logic        ce,
  input  logic [7:0]  in_data,
  input  logic        in_sop,
  input  logic        in_eop,
  input  logic [2:0]  in_sum,
  input  logic        in_valid,
  output logic        in_ready,
  input  logic        tag_on,
  input  logic [15:0] tag_info,
  output logic [7:0]  out_data,
  output logic        out_sop,
  output logic        out_eop,
  output logic [2:0]  out_sum,
  output logic        out_valid,
  input  logic        out_ready
);
  ins_state_t  st;
  ins_state_t  next_st;
  logic [1:0]  pos;
  logic [1:0]  next_pos;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic        tag_q;
  logic        next_tag_q;
  logic [15:0] info_q;
  logic [15:0] next_info_q;
  logic        take;

  always_comb begin
    next_st     = st;
    next_pos    = pos;
    next_cnt    = cnt;
    next_tag_q  = tag_q;
    next_info_q = info_q;
    take        = 1'b0;
    out_sop     = 1'b0;
    out_eop     = 1'b0;
    out_sum     = 3'h0;
    in_ready    = 1'b0;
    out_valid   = 1'b0;
    out_data    = in_data;
    unique case (st)
      I_PASS: begin
        // Without a tag request the byte passes unchanged.
        out_valid = in_valid;
        out_sop   = in_sop;
        out_eop   = in_eop;
        out_sum   = in_sum;
        in_ready  = out_ready;
        take      = in_valid && out_ready;
      end
      I_INSERT: begin
        out_valid = 1'b1;
        unique case (pos)
          2'h0: out_data = TAG_PROTO_ID[15:8];
          2'h1: out_data = TAG_PROTO_ID[7:0];
          2'h2: out_data = info_q[15:8];
          2'h3: out_data = info_q[7:0];
        endcase
        if (out_ready) begin
          next_pos = pos + 2'h1;
          if (pos == TAG_LAST_POS) begin
            next_st  = I_PASS;
            next_cnt = HDR_TAGGED;
          end
        end
      end
    endcase
    if (take) begin
      if (in_sop) begin
        next_tag_q  = tag_on;
        next_info_q = tag_info;
        next_cnt    = 4'h1;
      end else if (cnt < HDR_ADDR_BYTES) begin
        next_cnt = cnt + 4'h1;
      end
      if (in_eop) begin
        next_cnt = 4'h0;
      end else if (next_tag_q && next_cnt == HDR_ADDR_BYTES) begin
        next_st  = I_INSERT;
        next_pos = 2'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st     <= I_PASS;
      pos    <= 2'h0;
      cnt    <= 4'h0;
      tag_q  <= 1'b0;
      info_q <= COUNT_RESET;
    end else if (ce) begin
      st     <= next_st;
      pos    <= next_pos;
      cnt    <= next_cnt;
      tag_q  <= next_tag_q;
      info_q <= next_info_q;
    end
  end

endmodule : tx_tag_inserter

//--- rtl/tx_descriptor_dma.sv
// Transmit descriptor ring walker, buffer reader and status write-back.
//
// Function
// - Host sets ownership bit 31 only when buffer data is ready.
// - After sending a descriptor's data, the device clears its ownership.
// - Ring-end bit 30 sends the pointer back to the first descriptor.
// - First-segment bit 29 marks the start of a packet.
// - Last-segment bit 28 marks the end of a packet.
// - Large-send bit 27 only raises TX_LARGE_SEND_SEEN; the normal layout is always used.
// - Bit 18 requests IP header checksum insertion.
// - Bit 17 requests UDP checksum insertion.
// - Bit 16 requests TCP checksum insertion.
// - Bits 15 to 0 give the exact byte count read from the buffer.
// - Tag-insert bit puts 0x8100 right after the source address.
// - The two tag info bytes follow the inserted protocol identifier.
// - Without tag insertion the frame goes out exactly as supplied.
// - Buffer address low word at offset 8, high word at 12.
// - Write-back keeps ring-end, first and last flags, clears the rest.
`timescale 1ns/1ps
module tx_descriptor_dma
  import tx_dma_pkg::*;
#(
  parameter int IDX_W      = 8,
  parameter int FIFO_DEPTH = 8
) (
  input  logic             REF_CLK,
  input  logic             RST_B,
  input  logic             CE,
  input  logic             TX_ENABLE,
  input  logic             TX_POLL,
  input  logic [63:0]      TX_RING_BASE,
  output logic             TX_BUSY,
  output logic             TX_PAUSED,
  output logic [IDX_W-1:0] TX_DESC_INDEX,
  output logic             TX_DESC_DONE,
  output logic             TX_LARGE_SEND_SEEN,
  output logic [15:0]      TX_PKT_COUNT,
  output logic             MEM_REQ,
  output logic             MEM_WRITE,
  output logic [63:0]      MEM_ADDR,
  output logic [31:0]      MEM_WDATA,
  input  logic             MEM_ACK,
  input  logic [31:0]      MEM_RDATA,
  output logic [7:0]       TX_DATA,
  output logic             TX_SOP,
  output logic             TX_EOP,
  output logic [2:0]       TX_SUM_REQ,
  output logic             TX_VALID,
  input  logic             TX_READY
);
  dma_state_t       state;
  dma_state_t       next_state;
  logic [IDX_W-1:0] idx;
  logic [IDX_W-1:0] next_idx;
  logic [1:0]       word;
  logic [1:0]       next_word;
  logic [31:0]      cmd;
  logic [31:0]      next_cmd;
  logic [31:0]      tag;
  logic [31:0]      next_tag;
  logic [63:0]      ptr;
  logic [63:0]      next_ptr;
  logic [15:0]      rem;
  logic [15:0]      next_rem;
  logic [31:0]      data;
  logic [31:0]      next_data;
  logic             first;
  logic             next_first;
  logic             done;
  logic             next_done;
  logic             lgs;
  logic             next_lgs;
  logic [15:0]      pkts;
  logic [15:0]      next_pkts;
  logic             req;
  logic             next_req;
  logic             we;
  logic             next_we;
  logic [63:0]      addr;
  logic [63:0]      next_addr;
  logic [31:0]      wdata;
  logic [31:0]      next_wdata;
  logic [1:0]       addr_word;

  logic             src_valid;
  logic             src_ready;
  logic [7:0]       src_data;
  logic             src_sop;
  logic             src_eop;
  logic [2:0]       src_sum;
  logic [7:0]       ed_data;
  logic             ed_sop;
  logic             ed_eop;
  logic [2:0]       ed_sum;
  logic             ed_valid;
  logic             ed_ready;
  logic [STREAM_W-1:0] fifo_out;

  // Byte lane chosen by the low address bits, so any buffer alignment works.
  assign src_data = data[{ptr[1:0], 3'b000} +: 8];
  assign src_sop  = first && cmd[FIRST_SEG_BIT];
  assign src_eop  = (rem == 16'h1) && cmd[LAST_SEG_BIT];
  assign src_sum  = {cmd[IP_SUM_BIT], cmd[UDP_SUM_BIT], cmd[TCP_SUM_BIT]};

  always_comb begin
    next_state = state;
    next_idx   = idx;
    next_word  = word;
    next_cmd   = cmd;
    next_tag   = tag;
    next_ptr   = ptr;
    next_rem   = rem;
    next_data  = data;
    next_first = first;
    next_done  = 1'b0;
    next_lgs   = lgs;
    next_pkts  = pkts;
    src_valid  = 1'b0;
    unique case (state)
      S_IDLE: begin
        if (!TX_ENABLE) begin
          next_idx = '0;
        end else begin
          next_state = S_FETCH;
          next_word  = WORD_CMD;
        end
      end
      S_FETCH: begin
        if (MEM_ACK) begin
          next_word = word + 2'h1;
          unique case (word)
            WORD_CMD: begin
              next_cmd = MEM_RDATA;
              if (!MEM_RDATA[OWN_BIT]) begin
                next_state = S_PAUSE;
              end
            end
            WORD_TAG: next_tag = MEM_RDATA;
            WORD_ADDR_LO: next_ptr[31:0] = MEM_RDATA;
            WORD_ADDR_HI: begin
              next_ptr[63:32] = MEM_RDATA;
              // The large-send bit only raises a flag; layout stays normal.
              next_lgs   = lgs | cmd[LARGE_SEND_BIT];
              next_rem   = cmd[LEN_MSB:0];
              next_first = 1'b1;
              if (cmd[LEN_MSB:0] == COUNT_RESET) begin
                next_state = S_WB;
              end else begin
                next_state = S_READ;
              end
            end
          endcase
        end
      end
      S_PAUSE: begin
        // Only the host's poll or a disable leaves this state, as ownership is not
        // watched by the device while the descriptor is host-owned.
        if (!TX_ENABLE) begin
          next_state = S_IDLE;
        end else if (TX_POLL) begin
          next_state = S_FETCH;
          next_word  = WORD_CMD;
        end
      end
      S_READ: begin
        if (MEM_ACK) begin
          next_data  = MEM_RDATA;
          next_state = S_EMIT;
        end
      end
      S_EMIT: begin
        src_valid = 1'b1;
        if (src_ready) begin
          next_ptr   = ptr + 64'h1;
          next_rem   = rem - 16'h1;
          next_first = 1'b0;
          if (rem == 16'h1) begin
            next_state = S_WB;
          end else if (ptr[1:0] == 2'h3) begin
            next_state = S_READ;
          end
        end
      end
      S_WB: begin
        if (MEM_ACK) begin
          next_done = 1'b1;
          next_word = WORD_CMD;
          if (cmd[LAST_SEG_BIT]) begin
            next_pkts = pkts + 16'h1;
          end
          if (cmd[RING_END_BIT]) begin
            next_idx = '0;
          end else begin
            next_idx = idx + 1'b1;
          end
          next_state = TX_ENABLE ? S_FETCH : S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // Memory requests are registered and held until acknowledged.
  always_comb begin
    next_req  = (next_state == S_FETCH) || (next_state == S_READ) ||
                (next_state == S_WB);
    next_we   = (next_state == S_WB);
    addr_word = (next_state == S_WB) ? WORD_CMD : next_word;
    if (next_state == S_READ) begin
      next_addr = {next_ptr[63:2], 2'b00};
    end else begin
      next_addr = TX_RING_BASE + (64'(next_idx) << DESC_SHIFT) +
                  64'({addr_word, 2'b00});
    end
    // Status form: owner cleared, flags kept, low bits reserved zero.
    next_wdata = {1'b0, next_cmd[RING_END_BIT], next_cmd[FIRST_SEG_BIT],
                  next_cmd[LAST_SEG_BIT], 28'h0};
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= S_IDLE;
      idx   <= '0;
      word  <= WORD_CMD;
      cmd   <= WORD_RESET;
      tag   <= WORD_RESET;
      ptr   <= ADDR_RESET;
      rem   <= COUNT_RESET;
      data  <= WORD_RESET;
      first <= 1'b0;
      done  <= 1'b0;
      lgs   <= 1'b0;
      pkts  <= COUNT_RESET;
      req   <= 1'b0;
      we    <= 1'b0;
      addr  <= ADDR_RESET;
      wdata <= WORD_RESET;
    end else if (CE) begin
      state <= next_state;
      idx   <= next_idx;
      word  <= next_word;
      cmd   <= next_cmd;
      tag   <= next_tag;
      ptr   <= next_ptr;
      rem   <= next_rem;
      data  <= next_data;
      first <= next_first;
      done  <= next_done;
      lgs   <= next_lgs;
      pkts  <= next_pkts;
      req   <= next_req;
      we    <= next_we;
      addr  <= next_addr;
      wdata <= next_wdata;
    end
  end

  tx_tag_inserter u_tag (
    .clk       (REF_CLK),
    .rst_b     (RST_B),
    .ce        (CE),
    .in_data   (src_data),
    .in_sop    (src_sop),
    .in_eop    (src_eop),
    .in_sum    (src_sum),
    .in_valid  (src_valid),
    .in_ready  (src_ready),
    .tag_on    (tag[TAG_INSERT_BIT]),
    .tag_info  (tag[TAG_INFO_MSB:0]),
    .out_data  (ed_data),
    .out_sop   (ed_sop),
    .out_eop   (ed_eop),
    .out_sum   (ed_sum),
    .out_valid (ed_valid),
    .out_ready (ed_ready)
  );

  // A full FIFO stalls the buffer reader through the editor's ready.
  tx_byte_fifo #(
    .WIDTH (STREAM_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (REF_CLK),
    .rst_b    (RST_B),
    .ce       (CE),
    .wr_valid (ed_valid),
    .wr_ready (ed_ready),
    .wr_data  ({ed_sum, ed_sop, ed_eop, ed_data}),
    .rd_valid (TX_VALID),
    .rd_ready (TX_READY),
    .rd_data  (fifo_out)
  );

  // Checksum requests travel with every data byte to the MAC's engine; inserted tag bytes carry zero.
  assign TX_SUM_REQ         = fifo_out[12:10];
  assign TX_SOP             = fifo_out[9];
  assign TX_EOP             = fifo_out[8];
  assign TX_DATA            = fifo_out[7:0];
  assign TX_BUSY            = (state != S_IDLE);
  assign TX_PAUSED          = (state == S_PAUSE);
  assign TX_DESC_INDEX      = idx;
  assign TX_DESC_DONE       = done;
  assign TX_LARGE_SEND_SEEN = lgs;
  assign TX_PKT_COUNT       = pkts;
  assign MEM_REQ            = req;
  assign MEM_WRITE          = we;
  assign MEM_ADDR           = addr;
  assign MEM_WDATA          = wdata;

endmodule : tx_descriptor_dma

//--- tb/tx_mem_model.sv
// Behavioural system memory holding the descriptor ring and packet buffers.
`timescale 1ns/1ps
module tx_mem_model (
  input  logic        clk,
  input  logic        rst_b,
  input  logic        req,
  input  logic        write,
  input  logic [63:0] addr,
  input  logic [31:0] wdata,
  output logic        ack,
  output logic [31:0] rdata
);
  // Bit 32 of the address picks the buffer half, so a lost high word reads
  // descriptors instead of packet bytes.
  logic [31:0] mem [0:255];
  logic [1:0]  wait_cnt;
  logic        slow;
  logic [31:0] last;
  wire  [7:0]  idx = {addr[32], addr[8:2]};
  // Alternate prompt and slow answers; data lines never repeat when idle.
  assign ack   = req && (wait_cnt == (slow ? 2'h2 : 2'h0));
  assign rdata = (ack && !write) ? mem[idx] : ~last;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt <= 2'h0;
      slow     <= 1'b0;
      last     <= 32'h0;
    end else if (ack) begin
      wait_cnt <= 2'h0;
      slow     <= ~slow;
      last     <= rdata;
      if (write) mem[idx] <= wdata;
    end else if (req) wait_cnt <= wait_cnt + 2'h1;
  end
endmodule : tx_mem_model

//--- tb/tx_descriptor_dma_chk.sv
// Port-level assertions for the transmit descriptor DMA.
`timescale 1ns/1ps
module tx_descriptor_dma_chk
  import tx_dma_pkg::*;
#(
  parameter int IDX_W = 8
) (
  input logic             REF_CLK,
  input logic             RST_B,
  input logic             TX_POLL,
  input logic [63:0]      TX_RING_BASE,
  input logic             TX_PAUSED,
  input logic [IDX_W-1:0] TX_DESC_INDEX,
  input logic             TX_DESC_DONE,
  input logic             MEM_REQ,
  input logic             MEM_WRITE,
  input logic [63:0]      MEM_ADDR,
  input logic [31:0]      MEM_WDATA,
  input logic             MEM_ACK,
  input logic [7:0]       TX_DATA,
  input logic             TX_SOP,
  input logic             TX_EOP,
  input logic             TX_VALID,
  input logic             TX_READY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  wire wb_ack = MEM_REQ && MEM_WRITE && MEM_ACK;

  req_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ &&
    $stable(MEM_ADDR) && $stable(MEM_WRITE) && $stable(MEM_WDATA))
    else $error("memory request changed before its answer");
  done_after_wb_a: assert property (wb_ack |=> TX_DESC_DONE)
    else $error("no completion pulse after status write");
  done_cause_a: assert property (TX_DESC_DONE |->
    $past(MEM_WRITE) && $past(MEM_ACK) && $past(MEM_REQ))
    else $error("completion pulse without a status write");
  status_form_a: assert property (MEM_REQ && MEM_WRITE |->
    !MEM_WDATA[OWN_BIT] && MEM_WDATA[27:0] == 28'h0)
    else $error("status word keeps ownership or command bits");
  status_word0_a: assert property (MEM_REQ && MEM_WRITE |->
    MEM_ADDR[3:0] == 4'h0)
    else $error("status written to a word other than the first");
  pause_quiet_a: assert property (TX_PAUSED |-> !MEM_REQ)
    else $error("memory traffic while paused");
  stream_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID &&
    $stable(TX_DATA) && $stable(TX_SOP) && $stable(TX_EOP))
    else $error("stream byte changed while stalled");
  poll_fetch_a: assert property (TX_PAUSED && TX_POLL |-> ##[1:8]
    MEM_REQ && !MEM_WRITE &&
    MEM_ADDR == TX_RING_BASE + {TX_DESC_INDEX, 4'h0})
    else $error("poll did not refetch the paused descriptor");
  ring_wrap_a: assert property (wb_ack && MEM_WDATA[RING_END_BIT] |->
    ##[1:2] TX_DESC_INDEX == '0)
    else $error("index did not return to the ring start");
endmodule : tx_descriptor_dma_chk

bind tx_descriptor_dma tx_descriptor_dma_chk #(.IDX_W(IDX_W)) chk_i (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .TX_POLL(TX_POLL),
  .TX_RING_BASE(TX_RING_BASE), .TX_PAUSED(TX_PAUSED),
  .TX_DESC_INDEX(TX_DESC_INDEX), .TX_DESC_DONE(TX_DESC_DONE),
  .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR),
  .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .TX_DATA(TX_DATA),
  .TX_SOP(TX_SOP), .TX_EOP(TX_EOP), .TX_VALID(TX_VALID),
  .TX_READY(TX_READY));

//--- tb/tx_descriptor_dma_test.sv
// Self-checking bench for the transmit descriptor DMA.
`timescale 1ns/1ps
module tx_descriptor_dma_test;
  import tx_dma_pkg::*;
  logic        ref_clk, rst_b, tx_enable, tx_poll, tx_ready, ce;
  logic [63:0] ring_base;
  logic        tx_busy, tx_paused, tx_desc_done, large_seen;
  logic        mem_req, mem_write, mem_ack, tx_sop, tx_eop, tx_valid;
  logic [7:0]  tx_desc_index, tx_data;
  logic [15:0] pkt_count;
  logic [63:0] mem_addr;
  logic [31:0] mem_wdata, mem_rdata;
  logic [2:0]  tx_sum;
  logic [12:0] exp_q [$];
  logic [12:0] got;
  int          fails, n_checks, cyc, pos;

  tx_descriptor_dma #(.IDX_W(8), .FIFO_DEPTH(8)) uut (
    .REF_CLK(ref_clk), .RST_B(rst_b), .CE(ce), .TX_ENABLE(tx_enable),
    .TX_POLL(tx_poll), .TX_RING_BASE(ring_base), .TX_BUSY(tx_busy),
    .TX_PAUSED(tx_paused), .TX_DESC_INDEX(tx_desc_index),
    .TX_DESC_DONE(tx_desc_done), .TX_LARGE_SEND_SEEN(large_seen),
    .TX_PKT_COUNT(pkt_count), .MEM_REQ(mem_req), .MEM_WRITE(mem_write),
    .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_ACK(mem_ack),
    .MEM_RDATA(mem_rdata), .TX_DATA(tx_data), .TX_SOP(tx_sop),
    .TX_EOP(tx_eop), .TX_SUM_REQ(tx_sum), .TX_VALID(tx_valid),
    .TX_READY(tx_ready));
  tx_mem_model mem_i (
    .clk(ref_clk), .rst_b(rst_b), .req(mem_req), .write(mem_write),
    .addr(mem_addr), .wdata(mem_wdata), .ack(mem_ack), .rdata(mem_rdata));

  function automatic logic [7:0] bval(input int a);
    return a[7:0] ^ 8'h5A;
  endfunction : bval

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_checks++;
    if (seen !== want) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : check

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic put_desc(input int i, input logic [31:0] w0,
                          input logic [31:0] w1, input logic [31:0] lo);
    // The ring sits at byte 0x100, so descriptor words start at word 64.
    mem_i.mem[64+4*i]   = w0;
    mem_i.mem[64+4*i+1] = w1;
    mem_i.mem[64+4*i+2] = lo;
    mem_i.mem[64+4*i+3] = 32'h1;
  endtask : put_desc

  // Expected stream units are {sum, sop, eop, data}; sum only counts at sop.
  task automatic add_seg(input int a, input int len, input logic fs,
                         input logic ls, input logic [2:0] sum,
                         input logic tag, input logic [15:0] tci);
    logic [12:0] e;
    for (int i = 0; i < len; i++) begin
      if (tag && pos == 12) begin
        exp_q.push_back(13'h081);
        exp_q.push_back(13'h000);
        exp_q.push_back({5'h0, tci[15:8]});
        exp_q.push_back({5'h0, tci[7:0]});
      end
      e = {3'h0, 1'b0, ls && i == len - 1, bval(a + i)};
      if (fs && i == 0) e[12:9] = {sum, 1'b1};
      exp_q.push_back(e);
      pos++;
    end
    if (ls) pos = 0;
  endtask : add_seg

  task automatic wait_paused;
    // Write-back runs ahead of the wire, so also wait for the buffer to drain.
    for (int i = 0; i < 600 && (tx_paused !== 1'b1 || tx_valid !== 1'b0);
         i++) @(posedge ref_clk) #1;
  endtask : wait_paused

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // The long early stall lets the eight-entry buffer fill and refuse.
  always @(posedge ref_clk) begin
    #1;
    cyc++;
    tx_ready = !(cyc > 20 && cyc < 80) && (cyc[2:0] != 3'h3);
    if (cyc == 4000) begin
      fails++;
      close_out();
    end
  end

  // Sampled mid-cycle, where the pair is settled for the coming edge.
  always @(negedge ref_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      got = {tx_sop ? tx_sum : 3'h0, tx_sop, tx_eop, tx_data};
      check(exp_q.size() != 0, 1'b1);
      if (exp_q.size() != 0) check(got, exp_q.pop_front());
    end
  end

  initial begin
    rst_b = 1'b0;
    tx_enable = 1'b0;
    tx_poll = 1'b0;
    tx_ready = 1'b1;
    ce = 1'b1;
    ring_base = 64'h100;
    for (int w = 0; w < 128; w++)
      mem_i.mem[128+w] = {bval(4*w+3), bval(4*w+2), bval(4*w+1), bval(4*w)};
    put_desc(0, 32'hA004_000E, {14'h0, 2'h2, 3'h5, 1'b0, 4'h5, 8'hC3},
             32'h101);
    put_desc(1, 32'h9000_0003, 32'h0, 32'h181);
    put_desc(2, 32'hF803_0005, 32'h0, 32'h1C0);
    add_seg(32'h101, 14, 1'b1, 1'b0, 3'h4, 1'b1, 16'hA5C3);
    add_seg(32'h181, 3, 1'b0, 1'b1, 3'h0, 1'b0, 16'h0);
    add_seg(32'h1C0, 5, 1'b1, 1'b1, 3'h3, 1'b0, 16'h0);
    repeat (16) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    @(posedge ref_clk) #1 tx_enable = 1'b1;
    wait_paused();
    check(tx_paused, 1'b1);
    check(tx_busy, 1'b1);
    check(tx_desc_index, 8'h0);
    check(exp_q.size(), 0);
    check(mem_i.mem[64], 32'h2000_0000);
    check(mem_i.mem[68], 32'h1000_0000);
    check(mem_i.mem[72], 32'h7000_0000);
    check(pkt_count, 16'h2);
    check(large_seen, 1'b1);
    $display("Test ring_walk done");
    put_desc(0, 32'hB001_0002, 32'h0, 32'h1E3);
    add_seg(32'h1E3, 2, 1'b1, 1'b1, 3'h1, 1'b0, 16'h0);
    tx_poll = 1'b1;
    @(posedge ref_clk) #1 tx_poll = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 wait_paused();
    check(tx_desc_index, 8'h1);
    check(mem_i.mem[64], 32'h3000_0000);
    check(pkt_count, 16'h3);
    check(exp_q.size(), 0);
    $display("Test poll_resume done");
    tx_enable = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check(tx_busy, 1'b0);
    check(tx_desc_index, 8'h0);
    $display("Test disable done");
    close_out();
  end
endmodule : tx_descriptor_dma_test
